// [logic/splc_cfg.svh]
// Contract
// - Pointer holds first free word, grows upward
// - Pop predecrements; push writes then increments
// - Call push clears pushed counter upper byte
// - Exception push adds status low byte
// - Limit register takes no reset value
// - Limit bit 0 always zero
// - Push and address-check addresses compared with limit; pop address is not
// - Push at limit completes without trap
// - Next push beyond limit traps
// - Address below 0800h traps as underflow
`ifndef SPLC_CFG_SVH
`define SPLC_CFG_SVH

`define SPLC_SFR_END 16'h0800
`define SPLC_SP_RESET 16'h0800
`define SPLC_WORD_STEP 16'h0002
`define SPLC_ALIGN_MASK 16'hFFFE
`define SPLC_PC_HI_W 7
`define SPLC_PC_W 23

`endif

// [logic/splc_pkg.sv]
package splc_pkg;

  typedef enum logic [2:0]
  {
    SPLC_OP_NONE = 3'h0,
    SPLC_OP_PUSH = 3'h1,
    SPLC_OP_POP = 3'h2,
    SPLC_OP_CALL = 3'h3,
    SPLC_OP_EXC = 3'h4,
    SPLC_OP_EA_CHECK = 3'h5,
    SPLC_OP_SP_WRITE = 3'h6,
    SPLC_OP_LIMIT_WRITE = 3'h7
  } splc_op_t;

  typedef enum logic [1:0]
  {
    SPLC_IDLE = 2'b00,
    SPLC_PUSH_HI = 2'b01
  } splc_state_t;

  typedef struct packed
  {
    logic valid;
    splc_op_t op;
    logic [15:0] data;
    logic [22:0] pc;
    logic [7:0] status_low_byte;
  } splc_req_t;

  typedef struct packed
  {
    logic valid;
    logic write;
    logic [15:0] addr;
    logic [15:0] wdata;
  } splc_mem_t;

  typedef struct packed
  {
    logic trap;
    logic overflow;
    logic underflow;
    logic [15:0] addr;
  } splc_err_t;

endpackage

// [logic/splc_bound_check.sv]
`timescale 1ns/1ns
`include "splc_cfg.svh"

module splc_bound_check #(
  parameter int ADDR_W = 16
) (
  input wire logic [ADDR_W-1:0] ea,
  input wire logic [ADDR_W-1:0] limit,
  input wire logic check_limit,
  output logic overflow,
  output logic underflow
);

  logic [ADDR_W-1:0] sfr_end;

  assign sfr_end = ADDR_W'(`SPLC_SFR_END);

  // equality with the limit is still legal, only strictly above traps
  assign overflow = check_limit && (ea > limit);
  assign underflow = (ea < sfr_end);

endmodule

// [logic/splc_top.sv]
`timescale 1ns/1ns
`include "splc_cfg.svh"

module splc_top (
  input wire logic sys_clk,
  input wire logic rst_n,
  input splc_pkg::splc_req_t req,
  output splc_pkg::splc_mem_t mem,
  output splc_pkg::splc_err_t err,
  output logic busy,
  output logic [15:0] stack_pointer,
  output logic [15:0] stack_limit
);
  import splc_pkg::*;

  typedef struct packed
  {
    splc_state_t state;
    logic [15:0] stack_pointer;
    logic [15:0] stack_limit;
    logic [15:0] hi_word;
    splc_mem_t mem;
    splc_err_t err;
    logic busy;
  } splc_regs_t;

  splc_regs_t state_reg;
  splc_regs_t state_next;

  logic [15:0] check_ea;
  logic check_limit;
  logic overflow;
  logic underflow;
  logic [15:0] sp_inc;
  logic [15:0] sp_dec;
  logic [15:0] pc_lo;
  logic [6:0] pc_hi;
  logic take;

  assign sp_inc = state_reg.stack_pointer + `SPLC_WORD_STEP;
  assign sp_dec = state_reg.stack_pointer - `SPLC_WORD_STEP;
  assign pc_lo = req.pc[15:0];
  assign pc_hi = req.pc[`SPLC_PC_W-1:16];
  assign take = req.valid && (state_reg.state == SPLC_IDLE);

  // address under test: the slot a push fills, the slot a pop empties,
  // or an address the cpu built from the pointer
  always_comb
  begin
    check_ea = state_reg.stack_pointer;
    check_limit = 1'b0;
    if (state_reg.state == SPLC_PUSH_HI)
    begin
      check_ea = state_reg.stack_pointer;
      check_limit = 1'b1;
    end
    else if (take)
    begin
      unique case (req.op)
        SPLC_OP_PUSH, SPLC_OP_CALL, SPLC_OP_EXC:
        begin
          check_ea = state_reg.stack_pointer;
          check_limit = 1'b1;
        end
        SPLC_OP_POP:
        begin
          check_ea = sp_dec;
          check_limit = 1'b0;
        end
        SPLC_OP_EA_CHECK:
        begin
          check_ea = req.data & `SPLC_ALIGN_MASK;
          check_limit = 1'b1;
        end
        default:
        begin
          check_ea = state_reg.stack_pointer;
          check_limit = 1'b0;
        end
      endcase
    end
  end

  splc_bound_check #(
    .ADDR_W(16)
  ) u_bound (
    .ea(check_ea),
    .limit(state_reg.stack_limit),
    .check_limit(check_limit),
    .overflow(overflow),
    .underflow(underflow)
  );

  always_comb
  begin
    state_next = state_reg;
    state_next.mem.valid = 1'b0;
    state_next.mem.write = 1'b0;
    state_next.err.trap = 1'b0;
    state_next.err.overflow = 1'b0;
    state_next.err.underflow = 1'b0;

    unique case (state_reg.state)
      SPLC_IDLE:
      begin
        if (take)
        begin
          unique case (req.op)
            SPLC_OP_NONE:
            begin
              state_next.busy = 1'b0;
            end

            SPLC_OP_PUSH:
            begin
              if (overflow || underflow)
              begin
                // a faulting push is dropped so memory past the limit stays intact
                state_next.err.trap = 1'b1;
                state_next.err.overflow = overflow;
                state_next.err.underflow = underflow;
                state_next.err.addr = check_ea;
              end
              else
              begin
                state_next.mem.valid = 1'b1;
                state_next.mem.write = 1'b1;
                state_next.mem.addr = state_reg.stack_pointer;
                state_next.mem.wdata = req.data;
                state_next.stack_pointer = sp_inc;
              end
            end

            SPLC_OP_POP:
            begin
              // a pointer already under the boundary would wrap on the decrement
              if (underflow || (state_reg.stack_pointer < `SPLC_SFR_END))
              begin
                state_next.err.trap = 1'b1;
                state_next.err.underflow = 1'b1;
                state_next.err.addr = sp_dec;
              end
              else
              begin
                // pointer moves first, then the freed slot is read
                state_next.stack_pointer = sp_dec;
                state_next.mem.valid = 1'b1;
                state_next.mem.write = 1'b0;
                state_next.mem.addr = sp_dec;
                state_next.mem.wdata = 16'h0000;
              end
            end

            SPLC_OP_CALL, SPLC_OP_EXC:
            begin
              if (overflow || underflow)
              begin
                state_next.err.trap = 1'b1;
                state_next.err.overflow = overflow;
                state_next.err.underflow = underflow;
                state_next.err.addr = check_ea;
              end
              else
              begin
                state_next.mem.valid = 1'b1;
                state_next.mem.write = 1'b1;
                state_next.mem.addr = state_reg.stack_pointer;
                state_next.mem.wdata = pc_lo;
                state_next.stack_pointer = sp_inc;
                if (req.op == SPLC_OP_CALL)
                begin
                  state_next.hi_word = {8'h00, 1'b0, pc_hi};
                end
                else
                begin
                  state_next.hi_word = {req.status_low_byte, 1'b0, pc_hi};
                end
                state_next.state = SPLC_PUSH_HI;
                state_next.busy = 1'b1;
              end
            end

            SPLC_OP_EA_CHECK:
            begin
              if (overflow || underflow)
              begin
                state_next.err.trap = 1'b1;
                state_next.err.overflow = overflow;
                state_next.err.underflow = underflow;
                state_next.err.addr = check_ea;
              end
            end

            SPLC_OP_SP_WRITE:
            begin
              state_next.stack_pointer = req.data & `SPLC_ALIGN_MASK;
            end

            SPLC_OP_LIMIT_WRITE:
            begin
              // the new limit is live from the next cycle; an immediate pointer
              // read would be judged against it, which software is told to avoid
              state_next.stack_limit = req.data & `SPLC_ALIGN_MASK;
            end
          endcase
        end
      end

      SPLC_PUSH_HI:
      begin
        // the upper half of a counter push is a push of its own and may
        // itself cross the limit
        state_next.state = SPLC_IDLE;
        state_next.busy = 1'b0;
        if (overflow || underflow)
        begin
          state_next.err.trap = 1'b1;
          state_next.err.overflow = overflow;
          state_next.err.underflow = underflow;
          state_next.err.addr = check_ea;
        end
        else
        begin
          state_next.mem.valid = 1'b1;
          state_next.mem.write = 1'b1;
          state_next.mem.addr = state_reg.stack_pointer;
          state_next.mem.wdata = state_reg.hi_word;
          state_next.stack_pointer = sp_inc;
        end
      end

      default:
      begin
        state_next.state = SPLC_IDLE;
        state_next.busy = 1'b0;
      end
    endcase
  end

  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      state_reg.state <= SPLC_IDLE;
      state_reg.stack_pointer <= `SPLC_SP_RESET;
      // limit deliberately left alone: its content is unknown until written
      state_reg.stack_limit <= state_reg.stack_limit;
      state_reg.hi_word <= 16'h0000;
      state_reg.mem <= '0;
      state_reg.err <= '0;
      state_reg.busy <= 1'b0;
    end
    else
    begin
      state_reg <= state_next;
    end
  end

  assign mem = state_reg.mem;
  assign err = state_reg.err;
  assign busy = state_reg.busy;
  assign stack_pointer = state_reg.stack_pointer;
  assign stack_limit = state_reg.stack_limit;

endmodule

// [test/splc_top_assertions.sv]
`timescale 1ns/1ns
module splc_top_assertions (
  input wire logic sys_clk,
  input wire logic rst_n,
  input splc_pkg::splc_req_t req,
  input splc_pkg::splc_mem_t mem,
  input splc_pkg::splc_err_t err,
  input wire logic busy,
  input wire logic [15:0] stack_pointer,
  input wire logic [15:0] stack_limit
);
  import splc_pkg::*;
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!rst_n);
  wire logic tk = req.valid && !busy;
  wire logic [15:0] sp = stack_pointer;
  wire logic [15:0] ea = req.data & 16'hFFFE;
  wire logic ok = sp <= stack_limit && sp >= 16'h0800;
  wire logic psh = tk && req.op == SPLC_OP_PUSH;
  wire logic chk = tk && req.op == SPLC_OP_EA_CHECK;
  AST_LIMIT_MASK: assert property (
    tk && req.op == SPLC_OP_LIMIT_WRITE |=> stack_limit == $past(ea))
    else $error("limit value wrong");
  AST_PUSH: assert property (
    psh && ok |=> mem.valid && mem.write && mem.addr == $past(sp)
      && mem.wdata == $past(req.data) && sp == $past(sp) + 16'h0002)
    else $error("push access wrong");
  AST_AT_LIMIT: assert property (
    psh && sp == stack_limit && sp >= 16'h0800 |=> !err.trap && mem.valid)
    else $error("push at limit refused");
  AST_OVERFLOW: assert property (
    psh && sp > stack_limit |=> err.trap && err.overflow && !mem.valid && $stable(sp))
    else $error("push beyond limit not trapped");
  AST_POP: assert property (
    tk && req.op == SPLC_OP_POP && sp >= 16'h0802
      |=> mem.valid && !mem.write && mem.addr == sp && sp == $past(sp) - 16'h0002)
    else $error("pop access wrong");
  AST_EA_UNDER: assert property (
    chk && ea < 16'h0800 |=> err.trap && err.underflow && err.addr == $past(ea))
    else $error("underflow not trapped");
  AST_EA_OVER: assert property (
    chk && ea > stack_limit |=> err.trap && err.overflow)
    else $error("address above limit not trapped");
  AST_CALL_HI: assert property (
    tk && req.op == SPLC_OP_CALL && ok && sp < stack_limit
      |=> busy ##1 mem.valid && mem.wdata == {8'h00, 1'h0, $past(req.pc[22:16], 2)})
    else $error("call upper word wrong");
  AST_EXC_HI: assert property (
    tk && req.op == SPLC_OP_EXC && ok && sp < stack_limit |=> busy ##1 mem.valid
      && mem.wdata == {$past(req.status_low_byte, 2), 1'h0, $past(req.pc[22:16], 2)})
    else $error("exception upper word wrong");
  AST_TRAP_CAUSE: assert property (
    err.trap |-> $past(tk) || $past(busy))
    else $error("trap without request");
endmodule
bind splc_top splc_top_assertions u_chk (.sys_clk, .rst_n, .req, .mem, .err, .busy,
  .stack_pointer, .stack_limit);

// [test/splc_cpu_model.sv]
`timescale 1ns/1ns
module splc_cpu_model (
  input wire logic sys_clk,
  input splc_pkg::splc_req_t cmd,
  input wire logic busy,
  output splc_pkg::splc_req_t req
);
  import splc_pkg::*;
  always_ff @(posedge sys_clk)
  begin
    if (cmd.valid && !busy)
      req <= cmd;
    else
      // idle fields keep toggling so a stale value never looks like a request
      req <= {1'h0, ~req[$bits(splc_req_t)-2:0]};
  end
endmodule

// [test/test_stack_pointer_limit_check.sv]
`timescale 1ns/1ns
module test_stack_pointer_limit_check;
  import splc_pkg::*;
  typedef struct packed
  {
    splc_op_t op;
    logic [15:0] d;
    logic mv;
    logic [15:0] ma;
    logic tr;
    logic [15:0] sp;
  } splc_row_t;
  logic sys_clk = 1'h0;
  logic rst_n = 1'h0;
  splc_req_t cmd = '0;
  splc_req_t req;
  splc_mem_t mem;
  splc_err_t err;
  logic busy;
  logic [15:0] stack_pointer;
  logic [15:0] stack_limit;
  int n_mismatch = 0;
  int n_checks = 0;
  splc_row_t rows [14] = '{
    '{SPLC_OP_LIMIT_WRITE, 16'h0805, 1'h0, 16'h0000, 1'h0, 16'h0800},
    '{SPLC_OP_PUSH, 16'h1111, 1'h1, 16'h0800, 1'h0, 16'h0802},
    '{SPLC_OP_PUSH, 16'h2222, 1'h1, 16'h0802, 1'h0, 16'h0804},
    '{SPLC_OP_PUSH, 16'h3333, 1'h1, 16'h0804, 1'h0, 16'h0806},
    '{SPLC_OP_PUSH, 16'h4444, 1'h0, 16'h0000, 1'h1, 16'h0806},
    '{SPLC_OP_POP, 16'h0000, 1'h1, 16'h0804, 1'h0, 16'h0804},
    '{SPLC_OP_EA_CHECK, 16'h0807, 1'h0, 16'h0000, 1'h1, 16'h0804},
    '{SPLC_OP_EA_CHECK, 16'h07FE, 1'h0, 16'h0000, 1'h1, 16'h0804},
    '{SPLC_OP_SP_WRITE, 16'h0800, 1'h0, 16'h0000, 1'h0, 16'h0800},
    '{SPLC_OP_POP, 16'h0000, 1'h0, 16'h0000, 1'h1, 16'h0800},
    '{SPLC_OP_NONE, 16'h1234, 1'h0, 16'h0000, 1'h0, 16'h0800},
    '{SPLC_OP_SP_WRITE, 16'h0001, 1'h0, 16'h0000, 1'h0, 16'h0000},
    '{SPLC_OP_POP, 16'h0000, 1'h0, 16'h0000, 1'h1, 16'h0000},
    '{SPLC_OP_SP_WRITE, 16'h0800, 1'h0, 16'h0000, 1'h0, 16'h0800}};
  initial
  begin
    forever #5 sys_clk = ~sys_clk;
  end
  splc_cpu_model u_cpu (.sys_clk(sys_clk), .cmd(cmd), .busy(busy), .req(req));
  splc_top uut (.sys_clk(sys_clk), .rst_n(rst_n), .req(req), .mem(mem), .err(err),
    .busy(busy), .stack_pointer(stack_pointer), .stack_limit(stack_limit));
  task check(input logic ok, input string m);
    n_checks++;
    if (ok !== 1'h1)
    begin
      $display("unexpected at %0t: %s", $time, m);
      n_mismatch++;
    end
  endtask
  task end_of_test();
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  // every request is followed by idle cycles, so no pointer read follows a limit write
  task do_op(input splc_op_t op, input logic [15:0] d, input logic [22:0] pc,
    input logic [7:0] sb);
    @(posedge sys_clk);
    cmd <= '{1'h1, op, d, pc, sb};
    @(posedge sys_clk);
    cmd.valid <= 1'h0;
    @(posedge sys_clk);
    #1;
  endtask
  task check_wr(input logic [15:0] a, input logic [15:0] wd, input logic b);
    check(mem.valid === 1'h1 && mem.write === 1'h1 && mem.addr === a, "write address");
    check(mem.wdata === wd && busy === b, "write data");
  endtask
  initial
  begin
    repeat (3000) @(posedge sys_clk);
    n_mismatch++;
    end_of_test();
  end
  initial
  begin
    repeat (5) @(posedge sys_clk);
    rst_n <= 1'h1;
    foreach (rows[i])
    begin
      do_op(rows[i].op, rows[i].d, 23'h000000, 8'h00);
      check(mem.valid === rows[i].mv, "access strobe");
      if (rows[i].mv)
        check(mem.addr === rows[i].ma && mem.write === (rows[i].op == SPLC_OP_PUSH)
          && mem.wdata === (rows[i].op == SPLC_OP_PUSH ? rows[i].d : 16'h0000),
          "access fields");
      check(err.trap === rows[i].tr, "trap");
      check(stack_pointer === rows[i].sp, "pointer");
    end
    check(stack_limit === 16'h0804, "limit bit 0");
    do_op(SPLC_OP_LIMIT_WRITE, 16'h0FFE, 23'h000000, 8'h00);
    do_op(SPLC_OP_CALL, 16'h0000, 23'h5A1234, 8'h00);
    check_wr(16'h0800, 16'h1234, 1'h1);
    @(posedge sys_clk);
    #1;
    check_wr(16'h0802, 16'h005A, 1'h0);
    do_op(SPLC_OP_EXC, 16'h0000, 23'h7F0F0F, 8'hA5);
    check_wr(16'h0804, 16'h0F0F, 1'h1);
    @(posedge sys_clk);
    #1;
    check_wr(16'h0806, 16'hA57F, 1'h0);
    check(stack_pointer === 16'h0808, "pointer after exception push");
    @(posedge sys_clk);
    rst_n <= 1'h0;
    repeat (2) @(posedge sys_clk);
    #1;
    check(stack_pointer === 16'h0800 && busy === 1'h0, "reset state");
    check(stack_limit === 16'h0FFE, "limit kept over reset");
    end_of_test();
  end
endmodule
